// ---- inc/rca_map.vh ----
`ifndef RCA_MAP_VH
`define RCA_MAP_VH

// ---------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------------------
`define RCA_IDX_CTRL0      20'hFFF9D
`define RCA_IDX_CTRL1      20'hFFF9E
`define RCA_IDX_TIME       20'hFFFA0
`define RCA_IDX_DATE       20'hFFFA1
`define RCA_IDX_ALARM      20'hFFFA2
`define RCA_IDX_IRQ_STAT   20'hFFFA3
`define RCA_IDX_IRQ_MASK   20'hFFFA4
`define RCA_IDX_SUBSEC     20'hFFFA5

// ---------------------------------------------------------------------------
// Control register one field positions
// ---------------------------------------------------------------------------
`define RCA_C1_FREEZE_REQ  0
`define RCA_C1_FREEZE_STAT 1
`define RCA_C1_PER_FLAG    3
`define RCA_C1_ALM_FLAG    4
`define RCA_C1_PER_IRQ_EN  5
`define RCA_C1_ALM_IRQ_EN  6
`define RCA_C1_ALM_EN      7
`define RCA_C1_RESET       8'h00

// ---------------------------------------------------------------------------
// Interrupt status and mask bit positions
// ---------------------------------------------------------------------------
`define RCA_IRQ_PER        0
`define RCA_IRQ_ALM        1

// ---------------------------------------------------------------------------
// Calendar limits and bus answers
// ---------------------------------------------------------------------------
`define RCA_SEC_MAX        6'h3B
`define RCA_MIN_MAX        6'h3B
`define RCA_HOUR_MAX       5'h17
`define RCA_DAY_MAX        5'h1F
`define RCA_MON_MAX        4'hC
`define RCA_YEAR_MAX       7'h63
`define RCA_RESP_OKAY      2'h0
`define RCA_RESP_SLVERR    2'h2

`endif

// ---- src/rca_top.v ----
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "rca_map.vh"
module rca_top #(
   parameter SUB_W = 16
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        ce,
   input  wire        rtc_tick,
   input  wire        standby_mode,
   input  wire [21:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [21:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output wire        rtc_shared_irq
);

   // ------------------------------------------------------------------------
   // Byte merge under write strobes
   // ------------------------------------------------------------------------
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i])
               merge[8*i +: 8] = nw[8*i +: 8];
         end
      end
   endfunction

   // ------------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------------
   reg [21:0]      awaddr_r;
   reg             aw_got_r;
   reg [31:0]      wdata_r;
   reg [3:0]       wstrb_r;
   reg             w_got_r;
   reg             freeze_request_r;
   reg             freeze_status_flag_r;
   reg             periodic_event_flag_r;
   reg             alarm_match_flag_r;
   reg             periodic_irq_enable_r;
   reg             alarm_irq_enable_r;
   reg             alarm_match_enable_r;
   reg             rtc_run_enable_r;
   reg             run_q_r;
   reg             standby_q_r;
   reg             holdoff_r;
   reg [SUB_W-1:0] sub_r;
   reg             ovf_pend_r;
   reg             wr_pend_r;
   reg             time_pend_r;
   reg             date_pend_r;
   reg [31:0]      time_buf_r;
   reg [31:0]      date_buf_r;
   reg [5:0]       sec_r;
   reg [5:0]       min_r;
   reg [4:0]       hour_r;
   reg [4:0]       day_r;
   reg [3:0]       mon_r;
   reg [6:0]       year_r;
   reg [5:0]       alm_min_r;
   reg [4:0]       alm_hour_r;
   reg [1:0]       irq_stat_r;
   reg [1:0]       irq_mask_r;
   reg [5:0]       sec_nxt;
   reg [5:0]       min_nxt;
   reg [4:0]       hour_nxt;
   reg [4:0]       day_nxt;
   reg [3:0]       mon_nxt;
   reg [6:0]       year_nxt;
   reg [31:0]      rd_data;
   reg             rd_hit;

   wire [19:0] wr_idx = awaddr_r[21:2];
   wire [19:0] rd_idx = s_axi_araddr[21:2];
   wire        wr_go  = aw_got_r & w_got_r & ~s_axi_bvalid;
   wire        wr_hit = (wr_idx == `RCA_IDX_CTRL0) | (wr_idx == `RCA_IDX_CTRL1)
                      | (wr_idx == `RCA_IDX_TIME)  | (wr_idx == `RCA_IDX_DATE)
                      | (wr_idx == `RCA_IDX_ALARM) | (wr_idx == `RCA_IDX_IRQ_STAT)
                      | (wr_idx == `RCA_IDX_IRQ_MASK);
   wire        c1_wr  = wr_go & (wr_idx == `RCA_IDX_CTRL1) & wstrb_r[0];
   wire        tm_wr  = wr_go & (wr_idx == `RCA_IDX_TIME);
   wire        dt_wr  = wr_go & (wr_idx == `RCA_IDX_DATE);
   wire [31:0] tm_new = merge(time_buf_r, wdata_r, wstrb_r);
   wire [31:0] dt_new = merge(date_buf_r, wdata_r, wstrb_r);
   wire [7:0]  c1_rd  = {alarm_match_enable_r, alarm_irq_enable_r, periodic_irq_enable_r,
                         alarm_match_flag_r, periodic_event_flag_r, 1'b0,
                         freeze_status_flag_r, freeze_request_r};

   // Calendar counters hold while frozen or while a counter write waits to land
   wire hold     = freeze_request_r | wr_pend_r;
   wire sub_ovf  = rtc_tick & rtc_run_enable_r & (&sub_r);
   wire advance  = rtc_tick & rtc_run_enable_r & ~hold & (sub_ovf | ovf_pend_r);
   wire per_ev   = advance & periodic_irq_enable_r;
   wire alm_ev   = advance & alarm_match_enable_r & (sec_nxt == 6'h00)
                 & (min_nxt == alm_min_r) & (hour_nxt == alm_hour_r);
   wire [1:0] irq_ev = {alm_ev & alarm_irq_enable_r, per_ev};

   // ------------------------------------------------------------------------
   // Bus handshakes
   // ------------------------------------------------------------------------
   assign s_axi_awready  = ~aw_got_r & ~s_axi_bvalid;
   assign s_axi_wready   = ~w_got_r & ~s_axi_bvalid;
   assign s_axi_arready  = ~s_axi_rvalid;
   // One level line for both causes, gated by the mask
   assign rtc_shared_irq = |(irq_stat_r & irq_mask_r);

   // ------------------------------------------------------------------------
   // Calendar increment, one second at a time
   // ------------------------------------------------------------------------
   always @* begin
      sec_nxt  = sec_r + 6'h01;
      min_nxt  = min_r;
      hour_nxt = hour_r;
      day_nxt  = day_r;
      mon_nxt  = mon_r;
      year_nxt = year_r;
      if (sec_r >= `RCA_SEC_MAX) begin
         sec_nxt = 6'h00;
         min_nxt = min_r + 6'h01;
         if (min_r >= `RCA_MIN_MAX) begin
            min_nxt  = 6'h00;
            hour_nxt = hour_r + 5'h01;
            if (hour_r >= `RCA_HOUR_MAX) begin
               hour_nxt = 5'h00;
               day_nxt  = day_r + 5'h01;
               // Fixed 31-day months keep the adder small; software trims dates
               if (day_r >= `RCA_DAY_MAX) begin
                  day_nxt = 5'h01;
                  mon_nxt = mon_r + 4'h1;
                  if (mon_r >= `RCA_MON_MAX) begin
                     mon_nxt  = 4'h1;
                     year_nxt = (year_r >= `RCA_YEAR_MAX) ? 7'h00 : year_r + 7'h01;
                  end
               end
            end
         end
      end
   end

   // ------------------------------------------------------------------------
   // Read data mux
   // ------------------------------------------------------------------------
   always @* begin
      rd_hit  = 1'b1;
      rd_data = 32'h0000_0000;
      case (rd_idx)
         `RCA_IDX_CTRL0:    rd_data = {31'h0000_0000, rtc_run_enable_r};
         `RCA_IDX_CTRL1:    rd_data = {24'h00_0000, c1_rd};
         `RCA_IDX_TIME:     rd_data = {11'h000, hour_r, 2'h0, min_r, 2'h0, sec_r};
         `RCA_IDX_DATE:     rd_data = {9'h000, year_r, 4'h0, mon_r, 3'h0, day_r};
         `RCA_IDX_ALARM:    rd_data = {19'h0_0000, alm_hour_r, 2'h0, alm_min_r};
         `RCA_IDX_IRQ_STAT: rd_data = {30'h0000_0000, irq_stat_r};
         `RCA_IDX_IRQ_MASK: rd_data = {30'h0000_0000, irq_mask_r};
         `RCA_IDX_SUBSEC:   rd_data = {{(32-SUB_W){1'b0}}, sub_r};
         default:           rd_hit  = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------------
   // Bus slave: address and data may come in either order
   // ------------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_r     <= 22'h00_0000;
         aw_got_r     <= 1'b0;
         wdata_r      <= 32'h0000_0000;
         wstrb_r      <= 4'h0;
         w_got_r      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RCA_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `RCA_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_r <= s_axi_awaddr;
            aw_got_r <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            w_got_r <= 1'b1;
         end
         if (wr_go) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `RCA_RESP_OKAY : `RCA_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_hit ? `RCA_RESP_OKAY : `RCA_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Control, freeze handshake and calendar counting
   // ------------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         freeze_request_r      <= 1'b0;
         freeze_status_flag_r  <= 1'b0;
         periodic_event_flag_r <= 1'b0;
         alarm_match_flag_r    <= 1'b0;
         periodic_irq_enable_r <= 1'b0;
         alarm_irq_enable_r    <= 1'b0;
         alarm_match_enable_r  <= 1'b0;
         rtc_run_enable_r      <= 1'b0;
         run_q_r               <= 1'b0;
         standby_q_r           <= 1'b0;
         holdoff_r             <= 1'b0;
         sub_r                 <= {SUB_W{1'b0}};
         ovf_pend_r            <= 1'b0;
         wr_pend_r             <= 1'b0;
         time_pend_r           <= 1'b0;
         date_pend_r           <= 1'b0;
         time_buf_r            <= 32'h0000_0000;
         date_buf_r            <= 32'h0000_0000;
         sec_r                 <= 6'h00;
         min_r                 <= 6'h00;
         hour_r                <= 5'h00;
         day_r                 <= 5'h01;
         mon_r                 <= 4'h1;
         year_r                <= 7'h00;
         alm_min_r             <= 6'h00;
         alm_hour_r            <= 5'h00;
         irq_stat_r            <= 2'h0;
         irq_mask_r            <= 2'h0;
      end else if (ce) begin
         run_q_r     <= rtc_run_enable_r;
         standby_q_r <= standby_mode;

         // Sub-second counter never stops for a freeze; software has a second
         if (rtc_tick && rtc_run_enable_r)
            sub_r <= sub_r + {{(SUB_W-1){1'b0}}, 1'b1};
         if (sub_ovf && hold)
            ovf_pend_r <= 1'b1;
         else if (advance)
            ovf_pend_r <= 1'b0;

         // Calendar steps only when neither frozen nor awaiting a write
         if (advance) begin
            sec_r  <= sec_nxt;
            min_r  <= min_nxt;
            hour_r <= hour_nxt;
            day_r  <= day_nxt;
            mon_r  <= mon_nxt;
            year_r <= year_nxt;
         end

         // Buffered counter writes land on the next operating-clock tick
         if (rtc_tick && wr_pend_r) begin
            wr_pend_r   <= 1'b0;
            time_pend_r <= 1'b0;
            date_pend_r <= 1'b0;
            if (time_pend_r) begin
               sec_r      <= time_buf_r[5:0];
               min_r      <= time_buf_r[13:8];
               hour_r     <= time_buf_r[20:16];
               sub_r      <= {SUB_W{1'b0}};
               ovf_pend_r <= 1'b0;
            end
            if (date_pend_r) begin
               day_r  <= date_buf_r[4:0];
               mon_r  <= date_buf_r[11:8];
               year_r <= date_buf_r[22:16];
            end
         end
         // A new write in the landing cycle is kept, not lost
         if (tm_wr) begin
            time_buf_r  <= tm_new;
            time_pend_r <= 1'b1;
            wr_pend_r   <= 1'b1;
         end
         if (dt_wr) begin
            date_buf_r  <= dt_new;
            date_pend_r <= 1'b1;
            wr_pend_r   <= 1'b1;
         end

         // Status follows the request one tick later, or two after a restart
         if (rtc_tick) begin
            if (holdoff_r)
               holdoff_r <= 1'b0;
            else
               freeze_status_flag_r <= freeze_request_r | wr_pend_r;
         end
         if ((rtc_run_enable_r && !run_q_r) || (!standby_mode && standby_q_r))
            holdoff_r <= 1'b1;

         // Flags: an event wins over a clear; writing 1 leaves a flag alone
         periodic_event_flag_r <= per_ev | (periodic_event_flag_r
                                  & ~(c1_wr & ~wdata_r[`RCA_C1_PER_FLAG]));
         alarm_match_flag_r    <= alm_ev | (alarm_match_flag_r
                                  & ~(c1_wr & ~wdata_r[`RCA_C1_ALM_FLAG]));
         if (c1_wr) begin
            freeze_request_r      <= wdata_r[`RCA_C1_FREEZE_REQ];
            periodic_irq_enable_r <= wdata_r[`RCA_C1_PER_IRQ_EN];
            alarm_irq_enable_r    <= wdata_r[`RCA_C1_ALM_IRQ_EN];
            alarm_match_enable_r  <= wdata_r[`RCA_C1_ALM_EN];
         end

         // Other software registers
         if (wr_go && wr_idx == `RCA_IDX_CTRL0 && wstrb_r[0])
            rtc_run_enable_r <= wdata_r[0];
         if (wr_go && wr_idx == `RCA_IDX_ALARM) begin
            if (wstrb_r[0])
               alm_min_r <= wdata_r[5:0];
            if (wstrb_r[1])
               alm_hour_r <= wdata_r[12:8];
         end
         if (wr_go && wr_idx == `RCA_IDX_IRQ_MASK && wstrb_r[0])
            irq_mask_r <= wdata_r[1:0];
         if (wr_go && wr_idx == `RCA_IDX_IRQ_STAT && wstrb_r[0])
            irq_stat_r <= irq_ev | (irq_stat_r & ~wdata_r[1:0]);
         else
            irq_stat_r <= irq_ev | irq_stat_r;
      end
   end

endmodule

// ---- verification/rca_monitor.sv ----
`timescale 1ns/1ps
`include "rca_map.vh"
module rca_monitor #(
   parameter SUB_W = 16
) (
   input wire        aclk,
   input wire        aresetn,
   input wire        ce,
   input wire [21:0] s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [21:0] s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        rtc_shared_irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ------------------------------------------------------------------
   // Read target tracking
   // ------------------------------------------------------------------
   reg         rd_ctrl1_r;
   reg         rd_unmap_r;
   wire [19:0] ar_idx = s_axi_araddr[21:2];

   // Remember what the outstanding read aimed at, the answer comes later
   always @(posedge aclk) begin
      if (!aresetn) begin
         rd_ctrl1_r <= 1'b0;
         rd_unmap_r <= 1'b0;
      end else if (ce && s_axi_arvalid && s_axi_arready) begin
         rd_ctrl1_r <= (ar_idx == `RCA_IDX_CTRL1);
         rd_unmap_r <= (ar_idx < `RCA_IDX_CTRL0) || (ar_idx == 20'hFFF9F) ||
                       (ar_idx > `RCA_IDX_SUBSEC);
      end
   end

   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   a_write_answer: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |=> ##[0:1] s_axi_bvalid) else $error("write answer late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
      $stable(s_axi_bresp)) else $error("write answer dropped early");
   a_read_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
      $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped early");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_reset_quiet: assert property ($rose(aresetn) && $past(ce) |-> !s_axi_bvalid &&
      !s_axi_rvalid && !rtc_shared_irq) else $error("outputs busy after reset");
   a_ctrl_layout: assert property (s_axi_rvalid && rd_ctrl1_r |->
      s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[2] && s_axi_rresp == `RCA_RESP_OKAY)
      else $error("control register read malformed");
   a_unmapped_err: assert property (s_axi_rvalid && rd_unmap_r |->
      s_axi_rresp == `RCA_RESP_SLVERR) else $error("unmapped read not refused");
endmodule

bind rca_top rca_monitor #(.SUB_W(SUB_W)) i_mon (.aclk(aclk), .aresetn(aresetn), .ce(ce),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .rtc_shared_irq(rtc_shared_irq));

// ---- verification/rtc_counter_access_control_test.sv ----
`timescale 1ns/1ps
`include "rca_map.vh"
module rtc_counter_access_control_test;
   reg         aclk;
   reg         aresetn;
   reg         ce;
   reg         rtc_tick;
   reg         standby_mode;
   reg  [21:0] awaddr;
   reg         awvalid;
   reg  [31:0] wdata;
   reg         wvalid;
   reg         bready;
   reg  [21:0] araddr;
   reg         arvalid;
   reg         rready;
   wire        awready;
   wire        wready;
   wire [1:0]  bresp;
   wire        bvalid;
   wire        arready;
   wire [31:0] rdata;
   wire [1:0]  rresp;
   wire        rvalid;
   wire        irq;
   integer     bad_count;
   integer     n_tests;
   reg  [31:0] d;
   reg  [1:0]  r;

   // 8 ticks per second keeps the calendar scenarios short
   rca_top #(.SUB_W(3)) i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .rtc_tick(rtc_tick),
      .standby_mode(standby_mode), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .rtc_shared_irq(irq));

   // ------------------------------------------------------------------
   // Clock and helpers
   // ------------------------------------------------------------------
   always #2.5 aclk = ~aclk;

   task tally_and_finish;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, bad_count);
         if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask

   // Both write halves offered together, each released once taken
   task axi_wr(input [19:0] idx, input [31:0] v, output [1:0] resp);
      integer k;
      reg     done;
      begin
         done = 1'b0;
         resp = 2'h3;
         @(posedge aclk);
         awaddr <= {idx, 2'b00};
         wdata <= v;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         for (k = 0; k < 50 && !done; k = k + 1) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
               bready <= 1'b0;
               resp = bresp;
               done = 1'b1;
            end
         end
      end
   endtask

   task axi_rd(input [19:0] idx, output [31:0] v, output [1:0] resp);
      integer k;
      reg     done;
      begin
         done = 1'b0;
         v = 32'hFFFFFFFF;
         resp = 2'h3;
         @(posedge aclk);
         araddr <= {idx, 2'b00};
         arvalid <= 1'b1;
         rready <= 1'b1;
         for (k = 0; k < 50 && !done; k = k + 1) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
               rready <= 1'b0;
               v = rdata;
               resp = rresp;
               done = 1'b1;
            end
         end
      end
   endtask

   task wr(input [19:0] idx, input [31:0] v);
      begin
         axi_wr(idx, v, r);
         chk({30'h0, r}, {30'h0, `RCA_RESP_OKAY});
      end
   endtask

   // Masked read compare, a hang shows up as a bad response code
   task rd(input [19:0] idx, input [31:0] exp, input [31:0] m);
      begin
         axi_rd(idx, d, r);
         chk({30'h0, r}, {30'h0, `RCA_RESP_OKAY});
         chk(d & m, exp);
      end
   endtask

   // One operating-clock cycle is a single-cycle enable pulse
   task tick(input integer n);
      begin
         repeat (n) begin
            @(posedge aclk);
            rtc_tick <= 1'b1;
            @(posedge aclk);
            rtc_tick <= 1'b0;
         end
      end
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task t_reset_map;
      begin
         rd(`RCA_IDX_CTRL1, 32'h00000000, 32'hFFFFFFFF);
         axi_rd(20'hFFF9F, d, r);
         chk({30'h0, r}, {30'h0, `RCA_RESP_SLVERR});
         axi_wr(20'hFFFA7, 32'h00000001, r);
         chk({30'h0, r}, {30'h0, `RCA_RESP_SLVERR});
         $display("test reset_map done");
      end
   endtask

   // Overflow while frozen: dropped by a seconds write, else applied later
   task t_freeze;
      begin
         wr(`RCA_IDX_CTRL0, 32'h00000001);
         tick(2);
         wr(`RCA_IDX_CTRL1, 32'h00000001);
         tick(1);
         rd(`RCA_IDX_CTRL1, 32'h00000003, 32'h00000003);
         tick(10);
         wr(`RCA_IDX_TIME, 32'h00000005);
         tick(1);
         wr(`RCA_IDX_CTRL1, 32'h00000000);
         tick(3);
         rd(`RCA_IDX_TIME, 32'h00000005, 32'hFFFFFFFF);
         // Cleared at landing, then three ticks; an uncleared count would read 1
         rd(`RCA_IDX_SUBSEC, 32'h00000003, 32'hFFFFFFFF);
         rd(`RCA_IDX_CTRL1, 32'h00000000, 32'h00000003);
         wr(`RCA_IDX_CTRL1, 32'h00000001);
         tick(9);
         rd(`RCA_IDX_TIME, 32'h00000005, 32'hFFFFFFFF);
         // Three plus nine ticks modulo eight: the counter ran through the freeze
         rd(`RCA_IDX_SUBSEC, 32'h00000004, 32'hFFFFFFFF);
         wr(`RCA_IDX_CTRL1, 32'h00000000);
         tick(2);
         rd(`RCA_IDX_TIME, 32'h00000006, 32'hFFFFFFFF);
         $display("test freeze done");
      end
   endtask

   task t_clear_in_write;
      begin
         wr(`RCA_IDX_CTRL1, 32'h00000001);
         tick(1);
         wr(`RCA_IDX_TIME, 32'h00000010);
         wr(`RCA_IDX_CTRL1, 32'h00000000);
         rd(`RCA_IDX_CTRL1, 32'h00000002, 32'h00000003);
         tick(1);
         rd(`RCA_IDX_CTRL1, 32'h00000002, 32'h00000003);
         tick(1);
         rd(`RCA_IDX_CTRL1, 32'h00000000, 32'h00000003);
         $display("test clear_in_write done");
      end
   endtask

   task t_late_status;
      begin
         wr(`RCA_IDX_CTRL0, 32'h00000000);
         wr(`RCA_IDX_CTRL0, 32'h00000001);
         wr(`RCA_IDX_CTRL1, 32'h00000001);
         tick(2);
         rd(`RCA_IDX_CTRL1, 32'h00000003, 32'h00000003);
         wr(`RCA_IDX_CTRL1, 32'h00000000);
         tick(2);
         standby_mode <= 1'b1;
         tick(1);
         standby_mode <= 1'b0;
         wr(`RCA_IDX_CTRL1, 32'h00000001);
         tick(2);
         rd(`RCA_IDX_CTRL1, 32'h00000003, 32'h00000003);
         wr(`RCA_IDX_CTRL1, 32'h00000000);
         tick(2);
         rd(`RCA_IDX_CTRL1, 32'h00000000, 32'h00000003);
         $display("test late_status done");
      end
   endtask

   // Both causes fire at 00:01:00, flags kept by ones, cleared by zeros
   task t_irq;
      begin
         wr(`RCA_IDX_IRQ_MASK, 32'h00000003);
         wr(`RCA_IDX_ALARM, 32'h00000001);
         wr(`RCA_IDX_CTRL1, 32'h000000F8);
         wr(`RCA_IDX_TIME, 32'h0000003B);
         tick(10);
         rd(`RCA_IDX_TIME, 32'h00000100, 32'hFFFFFFFF);
         rd(`RCA_IDX_CTRL1, 32'h00000018, 32'h00000018);
         rd(`RCA_IDX_IRQ_STAT, 32'h00000003, 32'h00000003);
         chk({31'h0, irq}, 32'h00000001);
         wr(`RCA_IDX_CTRL1, 32'h000000F8);
         rd(`RCA_IDX_CTRL1, 32'h00000018, 32'h00000018);
         wr(`RCA_IDX_CTRL1, 32'h000000E8);
         rd(`RCA_IDX_CTRL1, 32'h00000008, 32'h00000018);
         wr(`RCA_IDX_CTRL1, 32'h000000E0);
         rd(`RCA_IDX_CTRL1, 32'h00000000, 32'h00000018);
         wr(`RCA_IDX_IRQ_STAT, 32'h00000001);
         rd(`RCA_IDX_IRQ_STAT, 32'h00000002, 32'h00000003);
         wr(`RCA_IDX_IRQ_MASK, 32'h00000001);
         chk({31'h0, irq}, 32'h00000000);
         wr(`RCA_IDX_IRQ_STAT, 32'h00000002);
         rd(`RCA_IDX_IRQ_STAT, 32'h00000000, 32'h00000003);
         $display("test irq done");
      end
   endtask

   // ------------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      ce = 1'b1;
      rtc_tick = 1'b0;
      standby_mode = 1'b0;
      awaddr = 22'h0;
      awvalid = 1'b0;
      wdata = 32'h0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 22'h0;
      arvalid = 1'b0;
      rready = 1'b0;
      bad_count = 0;
      n_tests = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset_map;
      t_freeze;
      t_clear_in_write;
      t_late_status;
      t_irq;
      tally_and_finish;
   end

   // The whole run needs a few hundred cycles, this is far beyond it
   initial begin
      #200000;
      bad_count = bad_count + 1;
      tally_and_finish;
   end
endmodule
